// file: rtl/bhdc_ctrl.sv
// Overview of operation
// (R01) current-limit trip ends the high-side pulse at the next clock edge
// (R02) overcurrent asserts the soft-start clamp output for that channel
// (R03) clamp enables only after sixteen overcurrent cycles are counted
// (R04) restart timer node held discharged while no restart is charging
// (R05) 512 limited cycles: soft-start pulled low, gates off, timer charges
// (R06) timer threshold: node discharged, soft-start released, restart
// (R07) four clean switching cycles clear the hiccup counter
// (R08) independent hiccup counters per channel, one shared timer
// (R09) last channel to expire restarts the charge; both restart together
// (R10) timer node strapped to supply at power-up disables hiccup
// (R11) high-side and low-side drives never on together
// (R12) low-side on only after high-side off, sensed low, and delay
// (R13) high-side on only after low-side sensed low and delay
// (R14) board straps mode pin to ground for independent dual outputs
// (R15) feedback strap: ground 5 V, supply 3.3 V, divider adjustable
// (R16) straps latched at power-up, relatched only after undervoltage
// (R17) limit comparator sampled once per switching cycle for counters
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module bhdc_ctrl (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CYCLE_START,
  input wire logic [1:0] PWM_CMD,
  input wire logic [1:0] CS_LIMIT,
  input wire logic [1:0] HS_GATE_LOW,
  input wire logic [1:0] LS_GATE_LOW,
  input wire logic RESTART_THRESH,
  input wire logic RESTART_TIED_HIGH,
  input wire logic [1:0] FB_STRAP_GND,
  input wire logic [1:0] FB_STRAP_SUP,
  input wire logic BIAS_UVLO,
  output logic [1:0] HS_DRIVE,
  output logic [1:0] LS_DRIVE,
  output logic [1:0] SS_PULLDOWN,
  output logic [1:0] SS_CLAMP,
  output logic RES_DISCHARGE,
  output logic RES_CHARGE,
  output logic [1:0] CH0_SETPOINT,
  output logic [1:0] CH1_SETPOINT,
  output logic IRQ
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic bhdc_pkg::bhdc_sp_t sp_decode(input logic gnd, input logic sup);
    if (gnd) begin
      return bhdc_pkg::SP_5V0;
    end else if (sup) begin
      return bhdc_pkg::SP_3V3;
    end
    return bhdc_pkg::SP_ADJ;
  endfunction

  function automatic bhdc_pkg::bhdc_gate_t gate_nxt(
    input bhdc_pkg::bhdc_gate_t st, input logic en, input logic hs_req,
    input logic hs_low, input logic ls_low, input logic dly_ok);
    bhdc_pkg::bhdc_gate_t nx;
    nx = st;
    case (st)
      bhdc_pkg::G_OFF: begin
        if (en) begin
          nx = hs_req ? bhdc_pkg::G_HWAIT : bhdc_pkg::G_LWAIT;
        end
      end
      bhdc_pkg::G_HWAIT: begin
        if (!en || !hs_req) begin
          nx = bhdc_pkg::G_OFF;
        end else if (ls_low && dly_ok) begin
          nx = bhdc_pkg::G_HON;
        end
      end
      bhdc_pkg::G_HON: begin
        if (!en) begin
          nx = bhdc_pkg::G_OFF;
        end else if (!hs_req) begin
          nx = bhdc_pkg::G_LWAIT;
        end
      end
      bhdc_pkg::G_LWAIT: begin
        if (!en) begin
          nx = bhdc_pkg::G_OFF;
        end else if (hs_req) begin
          nx = bhdc_pkg::G_HWAIT;
        end else if (hs_low && dly_ok) begin
          nx = bhdc_pkg::G_LON;
        end
      end
      bhdc_pkg::G_LON: begin
        if (!en) begin
          nx = bhdc_pkg::G_OFF;
        end else if (hs_req) begin
          nx = bhdc_pkg::G_HWAIT;
        end
      end
      default: begin
        nx = bhdc_pkg::G_OFF;
      end
    endcase
    return nx;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  bhdc_pkg::bhdc_strap_t strap_q;
  logic latched_q;
  logic [1:0] cl_seen_q, hit, expire, hic_q, hic_d, clamp_q, clamp_d;
  logic [1:0] hs_q, ls_q, en, hs_req;
  logic [4:0] oc_q [2];
  logic [9:0] hic_cnt_q [2];
  logic [2:0] clean_q [2];
  logic [2:0] dly_q [2];
  bhdc_pkg::bhdc_gate_t gst_q [2];
  bhdc_pkg::bhdc_tmr_t tmr_q, tmr_d;
  logic restart, dis_q, chg_q;
  logic [1:0] ctrl_q;
  bhdc_pkg::bhdc_evt_t ev, irq_st_q, irq_st_d, mask_q;
  bhdc_pkg::bhdc_status_t stat;
  logic irq_q;

  // ----------------------------------------
  // straps
  // ----------------------------------------
  // (R16) latch once, relatch after undervoltage
  always_ff @(posedge CLK) begin
    if (!RESETN || BIAS_UVLO) begin
      latched_q <= 1'b0;
    end else begin
      latched_q <= 1'b1;
    end
  end

  // (R15) per-channel setpoint decode
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      strap_q <= '0;
    end else if (!latched_q && !BIAS_UVLO) begin
      strap_q.sp0 <= sp_decode(FB_STRAP_GND[0], FB_STRAP_SUP[0]);
      strap_q.sp1 <= sp_decode(FB_STRAP_GND[1], FB_STRAP_SUP[1]);
      // (R10) timer node strap disables hiccup
      strap_q.hic_dis <= RESTART_TIED_HIGH;
    end
  end

  // ----------------------------------------
  // overcurrent and hiccup counting
  // ----------------------------------------
  assign hit = cl_seen_q | CS_LIMIT;
  assign restart = (tmr_q == bhdc_pkg::T_CHARGE) && RESTART_THRESH;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      expire[c] = CYCLE_START && hit[c] && (hic_cnt_q[c] == bhdc_pkg::HIC_LAST)
        && !hic_q[c] && !strap_q.hic_dis;
    end
    // (R09) any channel still in hiccup waits for the shared restart
    hic_d = (hic_q & ~{2{restart}}) | expire;
    for (int c = 0; c < 2; c++) begin
      clamp_d[c] = clamp_q[c];
      if (CYCLE_START) begin
        clamp_d[c] = hit[c] && (oc_q[c] >= bhdc_pkg::OC_ARM);
      end
      if (hic_d[c]) begin
        clamp_d[c] = 1'b0;
      end
    end
  end

  // (R17) one sample per switching cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cl_seen_q <= '0;
      for (int c = 0; c < 2; c++) begin
        oc_q[c] <= '0;
        hic_cnt_q[c] <= '0;
        clean_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (CYCLE_START) begin
          cl_seen_q[c] <= 1'b0;
        end else if (CS_LIMIT[c]) begin
          cl_seen_q[c] <= 1'b1;
        end
        if (CYCLE_START && hit[c]) begin
          clean_q[c] <= '0;
          // (R03) count overcurrent events
          if (oc_q[c] != bhdc_pkg::OC_EVENTS) begin
            oc_q[c] <= oc_q[c] + 5'h1;
          end
          // (R08) independent hiccup counter
          if (expire[c] || hic_q[c]) begin
            hic_cnt_q[c] <= '0;
          end else begin
            hic_cnt_q[c] <= hic_cnt_q[c] + 10'h1;
          end
        end else if (CYCLE_START && clean_q[c] == bhdc_pkg::CLEAN_LAST) begin
          // (R07) clean run clears counter
          clean_q[c] <= '0;
          hic_cnt_q[c] <= '0;
          oc_q[c] <= '0;
        end else if (CYCLE_START) begin
          clean_q[c] <= clean_q[c] + 3'h1;
        end
      end
    end
  end

  // (R02) clamp during overcurrent
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      clamp_q <= '0;
      hic_q <= '0;
    end else begin
      clamp_q <= clamp_d;
      // (R05) hiccup shutdown of channel
      hic_q <= hic_d;
    end
  end

  // ----------------------------------------
  // shared restart timer
  // ----------------------------------------
  always_comb begin
    tmr_d = tmr_q;
    case (tmr_q)
      bhdc_pkg::T_IDLE: tmr_d = bhdc_pkg::T_IDLE;
      bhdc_pkg::T_DISCH: tmr_d = bhdc_pkg::T_CHARGE;
      bhdc_pkg::T_CHARGE: tmr_d = restart ? bhdc_pkg::T_IDLE : bhdc_pkg::T_CHARGE;
      default: tmr_d = bhdc_pkg::T_IDLE;
    endcase
    // (R09) last expiry discharges and starts a new charge
    if (|expire) begin
      tmr_d = bhdc_pkg::T_DISCH;
    end
  end

  // (R04) discharge whenever not charging
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tmr_q <= bhdc_pkg::T_IDLE;
      dis_q <= 1'b1;
      chg_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      // (R06) threshold ends charge, node pulled low
      dis_q <= tmr_d != bhdc_pkg::T_CHARGE;
      chg_q <= tmr_d == bhdc_pkg::T_CHARGE;
    end
  end

  // ----------------------------------------
  // adaptive dead-time gate sequencing
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // (R05) gates disabled in hiccup
      en[c] = latched_q && ctrl_q[c] && !hic_d[c];
      // (R01) trip blocks high side for rest of cycle
      hs_req[c] = PWM_CMD[c] && !CS_LIMIT[c] && !cl_seen_q[c];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      hs_q <= '0;
      ls_q <= '0;
      for (int c = 0; c < 2; c++) begin
        gst_q[c] <= bhdc_pkg::G_OFF;
        dly_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        // (R12) wait for high-side gate low, then delay
        // (R13) wait for low-side gate low, then delay
        gst_q[c] <= gate_nxt(gst_q[c], en[c], hs_req[c], HS_GATE_LOW[c],
          LS_GATE_LOW[c], dly_q[c] >= bhdc_pkg::DT_CYC);
        if ((gst_q[c] == bhdc_pkg::G_HWAIT && LS_GATE_LOW[c])
            || (gst_q[c] == bhdc_pkg::G_LWAIT && HS_GATE_LOW[c])) begin
          dly_q[c] <= (dly_q[c] >= bhdc_pkg::DT_CYC) ? dly_q[c] : dly_q[c] + 3'h1;
        end else begin
          dly_q[c] <= '0;
        end
        // (R11) one state per drive, never both
        hs_q[c] <= gate_nxt(gst_q[c], en[c], hs_req[c], HS_GATE_LOW[c],
          LS_GATE_LOW[c], dly_q[c] >= bhdc_pkg::DT_CYC) == bhdc_pkg::G_HON;
        ls_q[c] <= gate_nxt(gst_q[c], en[c], hs_req[c], HS_GATE_LOW[c],
          LS_GATE_LOW[c], dly_q[c] >= bhdc_pkg::DT_CYC) == bhdc_pkg::G_LON;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic awr_q, wr_q, bv_q, arr_q, rv_q, aw_h_q, w_h_q;
  logic [3:0] aw_a_q;
  logic [31:0] w_d_q, rd_q;
  logic [3:0] w_s_q;
  logic [1:0] br_q, rr_q;
  logic aw_tk, w_tk, ar_tk, aw_now, w_now, do_wr, bv_d, rv_d, rd_clr;
  logic [3:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  assign aw_tk = S_AXI_AWVALID && awr_q;
  assign w_tk = S_AXI_WVALID && wr_q;
  assign ar_tk = S_AXI_ARVALID && arr_q;
  assign aw_now = aw_h_q || aw_tk;
  assign w_now = w_h_q || w_tk;
  assign do_wr = aw_now && w_now && !bv_q;
  assign wa = aw_h_q ? aw_a_q : S_AXI_AWADDR;
  assign wd = w_h_q ? w_d_q : S_AXI_WDATA;
  assign ws = w_h_q ? w_s_q : S_AXI_WSTRB;
  assign bv_d = do_wr || (bv_q && !S_AXI_BREADY);
  assign rv_d = ar_tk || (rv_q && !S_AXI_RREADY);
  assign rd_clr = ar_tk && S_AXI_ARADDR == bhdc_pkg::ADDR_IRQ_STAT;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aw_h_q <= 1'b0;
      w_h_q <= 1'b0;
      aw_a_q <= '0;
      w_d_q <= '0;
      w_s_q <= '0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= bhdc_pkg::RESP_OKAY;
    end else begin
      aw_h_q <= aw_now && !do_wr;
      w_h_q <= w_now && !do_wr;
      if (aw_tk) begin
        aw_a_q <= S_AXI_AWADDR;
      end
      if (w_tk) begin
        w_d_q <= S_AXI_WDATA;
        w_s_q <= S_AXI_WSTRB;
      end
      awr_q <= !(aw_now && !do_wr) && !bv_d;
      wr_q <= !(w_now && !do_wr) && !bv_d;
      bv_q <= bv_d;
      if (do_wr) begin
        br_q <= (wa == bhdc_pkg::ADDR_CTRL || wa == bhdc_pkg::ADDR_IRQ_MASK
          || wa == bhdc_pkg::ADDR_STATUS || wa == bhdc_pkg::ADDR_IRQ_STAT)
          ? bhdc_pkg::RESP_OKAY : bhdc_pkg::RESP_SLVERR;
      end
    end
  end

  // control writes steer channel enables and mask
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q <= bhdc_pkg::CTRL_RESET;
      mask_q <= '0;
    end else if (do_wr && ws[0]) begin
      if (wa == bhdc_pkg::ADDR_CTRL) begin
        ctrl_q <= wd[1:0];
      end
      if (wa == bhdc_pkg::ADDR_IRQ_MASK) begin
        mask_q <= wd[$bits(bhdc_pkg::bhdc_evt_t)-1:0];
      end
    end
  end

  always_comb begin
    stat = '0;
    stat.latched = latched_q;
    stat.tmr = tmr_q;
    stat.clamp = clamp_q;
    stat.hiccup = hic_q;
    stat.strap = strap_q;
    ev.restart = restart;
    ev.clamp = clamp_d & ~clamp_q;
    ev.hiccup = expire;
    // new event wins over read clear
    irq_st_d = (rd_clr ? '0 : irq_st_q) | ev;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= bhdc_pkg::RESP_OKAY;
      irq_st_q <= '0;
      irq_q <= 1'b0;
    end else begin
      arr_q <= !rv_d;
      rv_q <= rv_d;
      irq_st_q <= irq_st_d;
      irq_q <= |(irq_st_d & mask_q);
      if (ar_tk) begin
        rr_q <= bhdc_pkg::RESP_OKAY;
        case (S_AXI_ARADDR)
          bhdc_pkg::ADDR_CTRL: rd_q <= 32'(ctrl_q);
          bhdc_pkg::ADDR_STATUS: rd_q <= stat;
          bhdc_pkg::ADDR_IRQ_STAT: rd_q <= 32'(irq_st_q);
          bhdc_pkg::ADDR_IRQ_MASK: rd_q <= 32'(mask_q);
          default: begin
            rd_q <= '0;
            rr_q <= bhdc_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign S_AXI_AWREADY = awr_q;
  assign S_AXI_WREADY = wr_q;
  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP = br_q;
  assign S_AXI_ARREADY = arr_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rr_q;
  assign HS_DRIVE = hs_q;
  assign LS_DRIVE = ls_q;
  assign SS_PULLDOWN = hic_q;
  assign SS_CLAMP = clamp_q;
  assign RES_DISCHARGE = dis_q;
  assign RES_CHARGE = chg_q;
  assign CH0_SETPOINT = strap_q.sp0;
  assign CH1_SETPOINT = strap_q.sp1;
  assign IRQ = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_thresh;
    RES_CHARGE && RESTART_THRESH;
  endsequence

  chk_no_overlap: assert property (!(|(HS_DRIVE & LS_DRIVE))) // R11
    else $error("high and low drive on together");
  chk_cl_cut: assert property ((CS_LIMIT & HS_DRIVE) != '0 |=> (HS_DRIVE & $past(CS_LIMIT)) == '0) // R01
    else $error("high side not cut on limit");
  chk_hs_dead: assert property ($rose(HS_DRIVE[0]) |-> $past(LS_GATE_LOW[0]) && !$past(LS_DRIVE[0])) // R13
    else $error("high side on before low gate off");
  chk_ls_dead: assert property ($rose(LS_DRIVE[0]) |-> $past(HS_GATE_LOW[0]) && !$past(HS_DRIVE[0])) // R12
    else $error("low side on before high gate off");
  chk_hiccup_off: assert property (SS_PULLDOWN[0] |-> !HS_DRIVE[0] && !LS_DRIVE[0]) // R05
    else $error("gates active in hiccup");
  chk_res_hold: assert property (RES_CHARGE != RES_DISCHARGE) // R04
    else $error("timer node neither held nor charged");
  chk_restart_rel: assert property (s_thresh ##1 1'b1 |-> RES_DISCHARGE && SS_PULLDOWN == '0 ##1 !RES_CHARGE) // R06
    else $error("restart did not release");
  chk_clean_clear: assert property (CYCLE_START && !hit[0] && clean_q[0] == bhdc_pkg::CLEAN_LAST |=> hic_cnt_q[0] == '0) // R07
    else $error("clean run did not clear counter");
  chk_clamp_arm: assert property (SS_CLAMP[0] |-> oc_q[0] == bhdc_pkg::OC_EVENTS) // R03
    else $error("clamp before sixteen events");
  chk_hic_dis: assert property (strap_q.hic_dis && SS_PULLDOWN == '0 |=> SS_PULLDOWN == '0) // R10
    else $error("hiccup while disabled");

endmodule

`default_nettype wire

// file: rtl/bhdc_pkg.sv
package bhdc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int DT_NS = 20;
  localparam int DT_RAW = (DT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] DT_CYC = 3'(DT_RAW < 1 ? 1 : DT_RAW);

  // ----------------------------------------
  // protection counts
  // ----------------------------------------
  localparam int OC_COUNT = 16;
  localparam int HIC_CYCLES = 512;
  localparam int CLEAN_RUN = 4;
  localparam logic [4:0] OC_EVENTS = 5'(OC_COUNT);
  localparam logic [4:0] OC_ARM = 5'(OC_COUNT - 1);
  localparam logic [9:0] HIC_LAST = 10'(HIC_CYCLES - 1);
  localparam logic [2:0] CLEAN_LAST = 3'(CLEAN_RUN - 1);

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SP_5V0 = 2'h0,
    SP_3V3 = 2'h1,
    SP_ADJ = 2'h2
  } bhdc_sp_t;

  typedef enum logic [2:0] {
    G_OFF = 3'h0,
    G_HWAIT = 3'h1,
    G_HON = 3'h3,
    G_LWAIT = 3'h2,
    G_LON = 3'h6
  } bhdc_gate_t;

  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_DISCH = 2'h1,
    T_CHARGE = 2'h3
  } bhdc_tmr_t;

  typedef struct packed {
    logic hic_dis;
    bhdc_sp_t sp1;
    bhdc_sp_t sp0;
  } bhdc_strap_t;

  typedef struct packed {
    logic restart;
    logic [1:0] clamp;
    logic [1:0] hiccup;
  } bhdc_evt_t;

  typedef struct packed {
    logic [19:0] pad;
    logic latched;
    bhdc_tmr_t tmr;
    logic [1:0] clamp;
    logic [1:0] hiccup;
    bhdc_strap_t strap;
  } bhdc_status_t;

endpackage

// file: verification/bhdc_stage_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// power stage and timer comparator model
// ----------------------------------------
module bhdc_stage_model #(
  parameter int DECAY = 2,
  parameter int CHG = 100
) (
  input wire logic clk,
  input wire logic [1:0] hs_drive,
  input wire logic [1:0] ls_drive,
  input wire logic res_charge,
  output logic [1:0] hs_gate_low,
  output logic [1:0] ls_gate_low,
  output logic res_thresh
);
  int hs_cnt[2];
  int ls_cnt[2];
  int chg_cnt;

  // gate charge decays slowly after drive removal
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      hs_cnt[c] <= hs_drive[c] ? 0 : hs_cnt[c] + 1;
      ls_cnt[c] <= ls_drive[c] ? 0 : ls_cnt[c] + 1;
    end
    chg_cnt <= res_charge ? chg_cnt + 1 : 0;
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      hs_gate_low[c] = hs_cnt[c] >= DECAY;
      ls_gate_low[c] = ls_cnt[c] >= DECAY;
    end
    res_thresh = chg_cnt >= CHG;
  end
endmodule

`default_nettype wire

// file: verification/buck_hiccup_deadtime_control_test.sv
`timescale 1ns/10ps
`default_nettype none

module buck_hiccup_deadtime_control_test;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, cyc_start, tied, uvlo;
  logic awready, wready, bvalid, arready, rvalid, rdis, rchg, irq, thr;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rs, pwm, cs, hgl, lgl, sgnd, ssup, hs, ls, ssp, ssc, sp0, sp1;
  logic [1:0] hs_p, ls_p, hgl_p, lgl_p;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  bhdc_ctrl u_dut (
    .CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CYCLE_START(cyc_start), .PWM_CMD(pwm), .CS_LIMIT(cs), .HS_GATE_LOW(hgl),
    .LS_GATE_LOW(lgl), .RESTART_THRESH(thr), .RESTART_TIED_HIGH(tied),
    .FB_STRAP_GND(sgnd), .FB_STRAP_SUP(ssup), .BIAS_UVLO(uvlo), .HS_DRIVE(hs),
    .LS_DRIVE(ls), .SS_PULLDOWN(ssp), .SS_CLAMP(ssc), .RES_DISCHARGE(rdis),
    .RES_CHARGE(rchg), .CH0_SETPOINT(sp0), .CH1_SETPOINT(sp1), .IRQ(irq)
  );

  bhdc_stage_model #(.DECAY(2), .CHG(100)) u_stage (
    .clk(clk), .hs_drive(hs), .ls_drive(ls), .res_charge(rchg),
    .hs_gate_low(hgl), .ls_gate_low(lgl), .res_thresh(thr)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // limit trips mid cycle, never at the cycle pulse
  task automatic cyc(input logic [1:0] c, input int n);
    repeat (n) begin
      cs <= c;
      @(posedge clk);
      cs <= 2'h0;
      @(posedge clk);
      cyc_start <= 1'b1;
      @(posedge clk);
      cyc_start <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task rst;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // clock, watchdog, gate monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
    if (resetn) begin
      chk(hs & ls, 2'h0);
      chk(ls & ~ls_p & ~hgl_p, 2'h0);
      chk(hs & ~hs_p & ~lgl_p, 2'h0);
    end
    hs_p <= hs;
    ls_p <= ls;
    hgl_p <= hgl;
    lgl_p <= lgl;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cyc_start, cs, tied, uvlo} = '0;
    pwm = 2'h3;
    // feedback straps on this board: channel 0 to ground (5 V), channel 1 to supply (3.3 V)
    sgnd = 2'h1;
    ssup = 2'h2;
    rst();
    chk({sp1, sp0}, 4'h4);
    chk({rchg, rdis}, 2'h1);
    axr(bhdc_pkg::ADDR_STATUS);
    chk(rdv & 32'h81f, 32'h804);
    sgnd <= 2'h0;
    ssup <= 2'h1;
    repeat (3) @(posedge clk);
    chk({sp1, sp0}, 4'h4);
    uvlo <= 1'b1;
    @(posedge clk);
    uvlo <= 1'b0;
    repeat (3) @(posedge clk);
    chk({sp1, sp0}, 4'h9);
    $display("test straps done");

    axr(bhdc_pkg::ADDR_CTRL);
    chk(rdv, 32'h3);
    axw(bhdc_pkg::ADDR_IRQ_MASK, 32'h1f);
    axr(bhdc_pkg::ADDR_IRQ_MASK);
    chk(rdv, 32'h1f);
    axw(4'h2, 32'h0);
    chk(rs, bhdc_pkg::RESP_SLVERR);
    axr(4'h2);
    chk(32'(rs), 32'(bhdc_pkg::RESP_SLVERR));
    chk(rdv, 32'h0);
    axw(bhdc_pkg::ADDR_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    chk({hs, ls}, 4'h0);
    axw(bhdc_pkg::ADDR_CTRL, 32'h3);
    $display("test registers done");

    pwm <= 2'h0;
    repeat (10) @(posedge clk);
    chk({hs, ls}, 4'h3);
    pwm <= 2'h3;
    repeat (10) @(posedge clk);
    chk({hs, ls}, 4'hc);
    cs <= 2'h1;
    @(posedge clk);
    cs <= 2'h0;
    @(posedge clk);
    chk(hs, 2'h2);
    repeat (5) @(posedge clk);
    chk(hs, 2'h2);
    cyc_start <= 1'b1;
    @(posedge clk);
    cyc_start <= 1'b0;
    repeat (10) @(posedge clk);
    chk(hs, 2'h3);
    $display("test gates done");

    rst();
    cyc(2'h1, 15);
    chk(ssc, 2'h0);
    cyc(2'h1, 1);
    chk(ssc, 2'h1);
    cyc(2'h0, 1);
    chk(ssc, 2'h0);
    $display("test clamp done");

    rst();
    cyc(2'h1, 511);
    cyc(2'h0, 4);
    cyc(2'h1, 1);
    chk(ssp, 2'h0);
    rst();
    axw(bhdc_pkg::ADDR_IRQ_MASK, 32'h1);
    cyc(2'h1, 511);
    cyc(2'h0, 3);
    chk(irq, 1'b0);
    cyc(2'h1, 1);
    chk(ssp, 2'h1);
    chk({hs[0], ls[0]}, 2'h0);
    chk(hs[1], 1'b1);
    chk(irq, 1'b1);
    repeat (3) @(posedge clk);
    chk({rchg, rdis}, 2'h2);
    axr(bhdc_pkg::ADDR_IRQ_STAT);
    chk(rdv, 32'h5);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    while (ssp !== 2'h0) @(posedge clk);
    chk({rchg, rdis}, 2'h1);
    axr(bhdc_pkg::ADDR_IRQ_STAT);
    chk(rdv, 32'h10);
    $display("test hiccup done");

    rst();
    cyc(2'h1, 16);
    cyc(2'h3, 496);
    chk(ssp, 2'h1);
    cyc(2'h2, 16);
    chk(ssp, 2'h3);
    repeat (60) @(posedge clk);
    chk(ssp, 2'h3);
    while (ssp === 2'h3) @(posedge clk);
    chk(ssp, 2'h0);
    $display("test both channels done");

    tied <= 1'b1;
    rst();
    axr(bhdc_pkg::ADDR_STATUS);
    chk(rdv[4], 1'b1);
    cyc(2'h1, 512);
    chk(ssp, 2'h0);
    chk({rchg, rdis}, 2'h1);
    tied <= 1'b0;
    $display("test hiccup disable done");
    summarize();
  end
endmodule

`default_nettype wire
